// *** scr_regs.v ***
// System coprocessor register bank with control, translation, domain and fault registers.
`timescale 1ns/100ps
`include "scr_map.vh"
module scr_regs #(
	parameter [7:0] IMPLEMENTER = 8'h11,
	parameter [7:0] ARCH_CODE = 8'h01,
	parameter [11:0] PART_NATIVE = 12'h123,
	parameter [11:0] PART_ALT = 12'h456,
	parameter [3:0] REVISION = 4'h1,
	parameter [2:0] IC_SIZE = 3'h3,
	parameter [2:0] IC_ASSOC = 3'h1,
	parameter IC_MULT = 1'b0,
	parameter [1:0] IC_LINE = 2'h2,
	parameter [2:0] DC_SIZE = 3'h3,
	parameter [2:0] DC_ASSOC = 3'h1,
	parameter DC_MULT = 1'b0,
	parameter [1:0] DC_LINE = 2'h2,
	parameter SEPARATE = 1'b1
) (
	input wire mclk,
	input wire arst_n,
	input wire xferValid,
	input wire xferWrite,
	input wire xferPriv,
	input wire [3:0] regSel,
	input wire [2:0] opSel,
	input wire [3:0] secondaryRegisterField,
	input wire [31:0] xferWdata,
	output reg [31:0] xferRdata,
	output wire undefTrap,
	input wire highVectorStrap,
	input wire osMode,
	input wire dataFault,
	input wire fetchFault,
	input wire [3:0] faultDomain,
	input wire [3:0] faultType,
	input wire [31:0] faultVaddr,
	input wire multipleActive,
	input wire dataAccess,
	input wire [1:0] accessSize,
	input wire [1:0] accessAddrLow,
	input wire [3:0] accessDomain,
	output wire mmuOn,
	output wire dcacheOn,
	output wire icacheOn,
	output wire wbufOn,
	output wire sysProtect,
	output wire romProtect,
	output wire [31:0] vectorBase,
	output wire alignFault,
	output wire [31:0] tablePointer,
	output wire domainFault,
	output wire checkPerm,
	output wire skipPerm
);
	////////////////////////////////////////////////////////////////////////
	reg [31:0] ctrl_r;
	reg [31:0] ttb_r;
	reg [31:0] dom_r;
	reg [31:0] fstat_r;
	reg [31:0] faddr_r;
	reg multiFaulted_r;
	reg strapS1_r;
	reg strapS2_r;
	reg strapLoaded_r;
	reg strapV1_r;
	reg strapV2_r;
	wire access;
	wire wr;
	wire [31:0] identWord;
	wire [31:0] geoWord;
	wire captureFault;
	function [31:0] ctrlMerge;
		input [31:0] val;
		begin
			ctrlMerge = (val & `SCR_CTRL_WMASK) | `SCR_CTRL_ALWAYS1;
		end
	endfunction
	////////////////////////////////////////////////////////////////////////
	assign access = xferValid & xferPriv;
	assign undefTrap = xferValid & ~xferPriv;
	assign wr = access & xferWrite;
	assign identWord = {IMPLEMENTER, ARCH_CODE, (osMode ? PART_ALT : PART_NATIVE), REVISION};
	// Fields encode size, associativity, multiplier and line length.
	assign geoWord = {3'h0, `SCR_GEO_TYPE, SEPARATE, 3'h0, DC_SIZE, DC_ASSOC, DC_MULT, DC_LINE,
		3'h0, IC_SIZE, IC_ASSOC, IC_MULT, IC_LINE};
	////////////////////////////////////////////////////////////////////////
	// Strap is synchronised and loaded into the vector bit once the second stage holds a real sample.
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			strapS1_r <= 1'b0;
			strapS2_r <= 1'b0;
			strapV1_r <= 1'b0;
			strapV2_r <= 1'b0;
			strapLoaded_r <= 1'b0;
		end else begin
			strapS1_r <= highVectorStrap;
			strapS2_r <= strapS1_r;
			strapV1_r <= 1'b1;
			strapV2_r <= strapV1_r;
			strapLoaded_r <= strapV2_r;
		end
	end
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_r <= `SCR_CTRL_RESET | `SCR_CTRL_ALWAYS1;
		end else if (wr && regSel == `SCR_REG_CTRL) begin
			ctrl_r <= ctrlMerge(xferWdata);
		end else if (!strapLoaded_r) begin
			ctrl_r[`SCR_BIT_HIVEC] <= strapS2_r;
		end
	end
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ttb_r <= 32'h00000000;
			dom_r <= 32'h00000000;
		end else if (wr) begin
			if (regSel == `SCR_REG_TTB) begin
				ttb_r <= xferWdata & `SCR_TTB_MASK;
			end
			if (regSel == `SCR_REG_DOM) begin
				dom_r <= xferWdata;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Fault capture wins over a software write in the same cycle.
	assign captureFault = dataFault & ~(multipleActive & multiFaulted_r);
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			multiFaulted_r <= 1'b0;
		end else if (!multipleActive) begin
			multiFaulted_r <= 1'b0;
		end else if (dataFault) begin
			multiFaulted_r <= 1'b1;
		end
	end
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			fstat_r <= 32'h00000000;
			faddr_r <= 32'h00000000;
		end else begin
			if (captureFault) begin
				fstat_r <= {24'h000000, faultDomain, faultType};
			end else if (wr && regSel == `SCR_REG_FSTAT) begin
				fstat_r <= xferWdata & `SCR_FSTAT_MASK;
			end
			if (captureFault) begin
				faddr_r <= faultVaddr;
			end else if (wr && regSel == `SCR_REG_FADDR) begin
				faddr_r <= xferWdata;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			xferRdata <= 32'h00000000;
		end else if (access && !xferWrite) begin
			case (regSel)
				`SCR_REG_IDENT: begin
					if (opSel == `SCR_GEO_OP && secondaryRegisterField == `SCR_GEO_SEC) begin
						xferRdata <= geoWord;
					end else begin
						xferRdata <= identWord;
					end
				end
				`SCR_REG_CTRL: xferRdata <= ctrl_r;
				`SCR_REG_TTB: xferRdata <= ttb_r;
				`SCR_REG_DOM: xferRdata <= dom_r;
				`SCR_REG_FSTAT: xferRdata <= fstat_r;
				`SCR_REG_FADDR: xferRdata <= faddr_r;
				default: xferRdata <= 32'h00000000;
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////////
	assign mmuOn = ctrl_r[`SCR_BIT_MMU];
	assign dcacheOn = ctrl_r[`SCR_BIT_DCACHE] & ctrl_r[`SCR_BIT_MMU];
	assign wbufOn = ctrl_r[`SCR_BIT_WBUF] & ctrl_r[`SCR_BIT_MMU];
	assign icacheOn = ctrl_r[`SCR_BIT_ICACHE];
	assign sysProtect = ctrl_r[`SCR_BIT_SYSP];
	assign romProtect = ctrl_r[`SCR_BIT_ROMP];
	assign vectorBase = ctrl_r[`SCR_BIT_HIVEC] ? `SCR_VEC_HIGH : `SCR_VEC_LOW;
	assign alignFault = ctrl_r[`SCR_BIT_ALIGN] & dataAccess &
		(((accessSize == `SCR_SZ_WORD) & (accessAddrLow != 2'h0)) |
		((accessSize == `SCR_SZ_HALFW) & accessAddrLow[0]));
	assign tablePointer = ttb_r;
	scr_domain_lookup u_dom (
		.domainWord(dom_r),
		.domainSel(accessDomain),
		.domainFault(domainFault),
		.checkPerm(checkPerm),
		.skipPerm(skipPerm)
	);
endmodule // scr_regs

// *** scr_map.vh ***
// Constants of the system coprocessor register bank.
// Behaviour
// - Register 0 returns geometry only at op1/sec0.
// - Identification word fields: implementer, architecture, part, revision.
// - Geometry word fixed zeros, type 0010, split bit.
// - Instruction size base: 512 bytes doubling per code.
// - Instruction associativity base: direct doubling to 128-way.
// - Multiplier bit scales by 3/2, absent case.
// - Line length codes 8, 16, 32, 64 bytes.
// - Data cache fields use the same encodings.
// - Register 1 reads and writes control bits.
// - Reset clears control, vector bit from strap.
// - Vector bit selects low or high vector base.
// - Fixed control bits read constant, writes ignored.
// - Control bit positions for each enable.
// - Translation off forces data cache, buffer off.
// - Alignment check faults misaligned data accesses only.
// - Register 2 holds table pointer bits 31-14.
// - Register 3 holds sixteen 2-bit domain codes.
// - Fault status: domain, type; data faults only.
// - Multiple transfer captures first fault only.
// - Fault address captured on data faults only.
// - Software writes load fault registers directly.
// - One write enables all four functions together.
// - Unprivileged transfers take undefined instruction trap.
`ifndef SCR_MAP_VH
`define SCR_MAP_VH
`define SCR_REG_IDENT 4'h0
`define SCR_REG_CTRL 4'h1
`define SCR_REG_TTB 4'h2
`define SCR_REG_DOM 4'h3
`define SCR_REG_FSTAT 4'h5
`define SCR_REG_FADDR 4'h6
`define SCR_GEO_OP 3'h1
`define SCR_GEO_SEC 4'h0
`define SCR_CTRL_ALWAYS1 32'h00000070
`define SCR_CTRL_WMASK 32'h0000338F
`define SCR_CTRL_RESET 32'h00000000
`define SCR_BIT_MMU 0
`define SCR_BIT_ALIGN 1
`define SCR_BIT_DCACHE 2
`define SCR_BIT_WBUF 3
`define SCR_BIT_ENDIAN 7
`define SCR_BIT_SYSP 8
`define SCR_BIT_ROMP 9
`define SCR_BIT_ICACHE 12
`define SCR_BIT_HIVEC 13
`define SCR_TTB_MASK 32'hFFFFC000
`define SCR_FSTAT_MASK 32'h000000FF
`define SCR_VEC_LOW 32'h00000000
`define SCR_VEC_HIGH 32'hFFFF0000
`define SCR_GEO_TYPE 4'h2
`define SCR_DOM_NONE 2'h0
`define SCR_DOM_CLIENT 2'h1
`define SCR_DOM_RSVD 2'h2
`define SCR_DOM_MANAGER 2'h3
`define SCR_SZ_HALFW 2'h1
`define SCR_SZ_WORD 2'h2
`endif

// *** scr_domain_lookup.v ***
// Domain code lookup that turns a domain number into an access decision.
`timescale 1ns/100ps
`include "scr_map.vh"
module scr_domain_lookup (
	input wire [31:0] domainWord,
	input wire [3:0] domainSel,
	output reg domainFault,
	output reg checkPerm,
	output reg skipPerm
);
	reg [1:0] code;
	always @* begin
		code = domainWord[{domainSel, 1'b0} +: 2];
		domainFault = 1'b0;
		checkPerm = 1'b0;
		skipPerm = 1'b0;
		case (code)
			`SCR_DOM_NONE: domainFault = 1'b1;
			`SCR_DOM_CLIENT: checkPerm = 1'b1;
			`SCR_DOM_RSVD: domainFault = 1'b1;
			`SCR_DOM_MANAGER: skipPerm = 1'b1;
			default: domainFault = 1'b1;
		endcase
	end
endmodule // scr_domain_lookup

// *** scr_regs_monitor.sv ***
// Checker of the coprocessor register bank ports.
`timescale 1ns/100ps
module scr_regs_monitor (
	input logic mclk,
	input logic arst_n,
	input logic xferValid,
	input logic xferWrite,
	input logic xferPriv,
	input logic [3:0] regSel,
	input logic [31:0] xferRdata,
	input logic undefTrap,
	input logic mmuOn,
	input logic dcacheOn,
	input logic wbufOn,
	input logic domainFault,
	input logic checkPerm,
	input logic skipPerm
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	wire rdTake = xferValid && xferPriv && !xferWrite;
	////////////////////////////////////////
	property p_trap; undefTrap == (xferValid && !xferPriv); endproperty
	a_trap: assert property (p_trap) else $error("trap");
	property p_dc; dcacheOn |-> mmuOn; endproperty
	a_dc: assert property (p_dc) else $error("dcache");
	property p_wb; wbufOn |-> mmuOn; endproperty
	a_wb: assert property (p_wb) else $error("wbuf");
	property p_dom; $onehot({domainFault, checkPerm, skipPerm}); endproperty
	a_dom: assert property (p_dom) else $error("domain");
	property p_ctl; rdTake && regSel == 4'h1 |=> xferRdata[6:4] == 3'h7 && xferRdata[14:10] ==? 5'b0??00; endproperty
	a_ctl: assert property (p_ctl) else $error("ctrl");
	property p_ttb; rdTake && regSel == 4'h2 |=> xferRdata[13:0] == 14'h0; endproperty
	a_ttb: assert property (p_ttb) else $error("table");
	property p_fst; rdTake && regSel == 4'h5 |=> xferRdata[31:8] == 24'h0; endproperty
	a_fst: assert property (p_fst) else $error("status");
	property p_hold; !rdTake |=> $stable(xferRdata); endproperty
	a_hold: assert property (p_hold) else $error("hold");
	c_ctl: cover property (rdTake && regSel == 4'h1);
	c_trap: cover property (undefTrap);
	c_on: cover property (wbufOn && dcacheOn);
endmodule // scr_regs_monitor

// *** scr_core_model.sv ***
// Behavioural core that issues coprocessor transfers.
`timescale 1ns/100ps
module scr_core_model (
	input wire mclk,
	input wire [31:0] xferRdata,
	output reg xferValid = 1'h0,
	output reg xferWrite = 1'h0,
	output reg xferPriv = 1'h0,
	output reg [3:0] regSel = 4'h0,
	output reg [2:0] opSel = 3'h0,
	output reg [3:0] secondaryRegisterField = 4'h0,
	output reg [31:0] xferWdata = 32'h0
);
	// Request held over the taking edge, answer read one edge later.
	task xfer(input w, p, input [3:0] r, input [2:0] o, input [3:0] s, input [31:0] d, output [31:0] q);
		@(posedge mclk);
		{xferValid, xferWrite, xferPriv, regSel, opSel} <= {1'h1, w, p, r, o};
		{secondaryRegisterField, xferWdata} <= {s, d};
		@(posedge mclk);
		xferValid <= 1'h0;
		xferWdata <= ~d;
		@(posedge mclk);
		#1 q = xferRdata;
	endtask
endmodule // scr_core_model

// *** tb.sv ***
// Self-checking bench of the system coprocessor register bank.
`timescale 1ns/100ps
`define CHK(a, e) begin samplesChecked++; if ((a) !== (e)) begin badCount++; $display("mismatch %0t %h %h", $time, a, e); end end
module tb;
	logic mclk = 1'h0, arst_n = 1'h0, highVectorStrap = 1'h1, osMode = 1'h0, dataFault = 1'h0;
	logic fetchFault = 1'h0, multipleActive = 1'h0, dataAccess = 1'h0;
	logic [1:0] accessSize = 2'h2, accessAddrLow = 2'h0;
	logic [3:0] faultDomain = 4'h0, faultType = 4'h0, accessDomain = 4'h0;
	logic [31:0] faultVaddr = 32'h0, q;
	logic [15:0] alignPat = 16'h658A, domExp = 16'h2949;
	logic xferValid, xferWrite, xferPriv, undefTrap, mmuOn, dcacheOn, icacheOn, wbufOn, sysProtect, romProtect;
	logic alignFault, domainFault, checkPerm, skipPerm;
	logic [3:0] regSel, secondaryRegisterField;
	logic [2:0] opSel;
	logic [31:0] xferWdata, xferRdata, vectorBase, tablePointer;
	int badCount = 0, samplesChecked = 0, cycles = 0;
	scr_core_model core (.*);
	scr_regs dut (.*);
	task endSim();
		if (badCount == 0 && samplesChecked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task wr(input [3:0] r, input [31:0] d);
		core.xfer(1'h1, 1'h1, r, 3'h0, 4'h0, d, q);
	endtask
	task rd(input [3:0] r, input [2:0] o, input [3:0] s, input [31:0] e);
		core.xfer(1'h0, 1'h1, r, o, s, 32'h0, q);
		`CHK(q, e)
	endtask
	task pulse(input isData, input [7:0] st, input [31:0] va);
		@(posedge mclk);
		{dataFault, fetchFault, faultDomain, faultType, faultVaddr} <= {isData, !isData, st, va};
		@(posedge mclk);
		{dataFault, fetchFault} <= 2'h0;
	endtask
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 1000) begin
			badCount++;
			endSim();
		end
	end
	////////////////////////////////////////
	initial forever #50 mclk = ~mclk;
	initial begin
		repeat (5) @(posedge mclk);
		arst_n <= 1'h1;
		repeat (3) @(posedge mclk);
		@(negedge mclk) `CHK({mmuOn, vectorBase}, {1'h0, 32'hFFFF0000})
		rd(4'h1, 3'h0, 4'h0, 32'h00002070);
		wr(4'h1, 32'h00005C0F);
		rd(4'h1, 3'h0, 4'h0, 32'h0000107F);
		`CHK({mmuOn, dcacheOn, wbufOn, icacheOn, vectorBase}, {4'hF, 32'h0})
		wr(4'h1, 32'h0000130E);
		rd(4'h1, 3'h0, 4'h0, 32'h0000137E);
		`CHK({mmuOn, dcacheOn, wbufOn, icacheOn, sysProtect, romProtect}, 6'h07)
		rd(4'h0, 3'h0, 4'h0, 32'h11011231);
		@(posedge mclk) osMode <= 1'h1;
		rd(4'h0, 3'h7, 4'h0, 32'h11014561);
		rd(4'h0, 3'h1, 4'h1, 32'h11014561);
		wr(4'h0, 32'h0);
		rd(4'h0, 3'h1, 4'h0, 32'h050CA0CA);
		wr(4'h2, 32'hFFFFC000);
		core.xfer(1'h1, 1'h0, 4'h2, 3'h0, 4'h0, 32'h0, q);
		rd(4'h2, 3'h0, 4'h0, 32'hFFFFC000);
		wr(4'h3, 32'h000000E4);
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk) {dataAccess, accessDomain, accessSize, accessAddrLow} <= {1'h1, i[3:0], alignPat[4 * i +: 4]};
			@(negedge mclk) `CHK({domainFault, checkPerm, skipPerm, alignFault}, domExp[4 * i +: 4])
		end
		wr(4'h5, 32'h000000A5);
		wr(4'h6, 32'h12345678);
		pulse(1'h0, 8'h37, 32'hCAFE0000);
		rd(4'h5, 3'h0, 4'h0, 32'h000000A5);
		rd(4'h6, 3'h0, 4'h0, 32'h12345678);
		pulse(1'h1, 8'h37, 32'hCAFE0000);
		rd(4'h5, 3'h0, 4'h0, 32'h00000037);
		rd(4'h6, 3'h0, 4'h0, 32'hCAFE0000);
		@(posedge mclk) multipleActive <= 1'h1;
		pulse(1'h1, 8'h4A, 32'h00001000);
		pulse(1'h1, 8'h5B, 32'h00002000);
		@(posedge mclk) multipleActive <= 1'h0;
		rd(4'h5, 3'h0, 4'h0, 32'h0000004A);
		rd(4'h6, 3'h0, 4'h0, 32'h00001000);
		endSim();
	end
endmodule // tb
bind scr_regs scr_regs_monitor mon (.*);
